// >>> hdl/sbk_ctrl.sv
`default_nettype none
module sbk_ctrl #(
  parameter int NGPO = 4,  // General outputs
  parameter int NCH  = 4,  // Channels
  parameter int NERR = 8   // Diagnostic enables
) (
  input  wire logic                      clk_i,       // 20 MHz clock
  input  wire logic                      rst_i,       // Sync reset, high
  input  wire logic                      wb_cyc_i,    // Bus cycle
  input  wire logic                      wb_stb_i,    // Bus strobe
  input  wire logic                      wb_we_i,     // Write
  input  wire logic [sbk_pkg::WB_AW-1:0] wb_adr_i,    // Byte address
  input  wire logic [3:0]                wb_sel_i,    // Byte lanes
  input  wire logic [sbk_pkg::WB_DW-1:0] wb_dat_i,    // Write data
  output logic      [sbk_pkg::WB_DW-1:0] wb_dat_o,    // Read data
  output logic                           wb_ack_o,    // Acknowledge
  input  wire logic                      standby_i,   // Core in standby
  output logic      [NGPO-1:0]           gpo_o,       // Output levels
  output logic      [NGPO-1:0]           gpo_oe_n_o,  // Output enables, low
  output logic      [NERR-1:0]           diag_en_o,   // Live diagnostics
  output logic                           osc_run_o,   // Keep oscillator on
  output logic                           lowside_sw_o // Switch closed
);
  import sbk_pkg::*;

  logic [31:0] misc_q, io_q, err_q, adc_q, chan_q;
  logic [31:0] misc_d, io_d, err_d, adc_d, chan_d;
  logic        ack_q;
  logic [31:0] rdat_q;

  // Bus decode; one access per handshake, the ack flop stops repeats
  wire         req     = wb_cyc_i && wb_stb_i && !ack_q;
  wire         wr      = req && wb_we_i;
  wire [31:0]  lane    = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}},
                          {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
  wire         hit_misc = wb_adr_i == ADR_MISC;
  wire         hit_io   = wb_adr_i == ADR_IO;
  wire         hit_err  = wb_adr_i == ADR_ERR;
  wire         hit_adc  = wb_adr_i == ADR_ADC;
  wire         hit_chan = wb_adr_i == ADR_CHAN;
  wire         hit_stat = wb_adr_i == ADR_STAT;

  // Merge written lanes into writable bits only, so reserved bits stay zero
  wire [31:0]  m_misc = (wr && hit_misc) ? (lane & MISC_WMASK) : 32'h0000_0000;
  wire [31:0]  m_io   = (wr && hit_io)   ? (lane & IO_WMASK)   : 32'h0000_0000;
  wire [31:0]  m_err  = (wr && hit_err)  ? (lane & ERR_WMASK)  : 32'h0000_0000;
  wire [31:0]  m_adc  = (wr && hit_adc)  ? (lane & ADC_WMASK)  : 32'h0000_0000;
  wire [31:0]  m_chan = (wr && hit_chan) ? (lane & CHAN_WMASK) : 32'h0000_0000;
  assign misc_d = (misc_q & ~m_misc) | (wb_dat_i & m_misc);
  assign io_d   = (io_q & ~m_io) | (wb_dat_i & m_io);
  assign err_d  = (err_q & ~m_err) | (wb_dat_i & m_err);
  assign adc_d  = (adc_q & ~m_adc) | (wb_dat_i & m_adc);
  assign chan_d = (chan_q & ~m_chan) | (wb_dat_i & m_chan);

  // Named fields of the control registers
  wire              route     = misc_q[MISC_ROUTE_BIT];
  wire              diag_keep = misc_q[MISC_DIAG_BIT];
  wire              gpo_keep  = misc_q[MISC_GPO_BIT];
  wire              sw_keep   = misc_q[MISC_SW_BIT];
  wire [NGPO-1:0]   io_en     = io_q[IO_EN_LSB +: NGPO];
  wire [NGPO-1:0]   io_dat    = io_q[IO_DAT_LSB +: NGPO];
  wire [NERR-1:0]   err_en    = err_q[NERR-1:0];
  wire [1:0]        clk_sel   = adc_q[CLK_SEL_LSB +: 2];
  wire [NCH-1:0]    ch_sw     = chan_q[CHAN_SW_LSB +: NCH];
  wire [NCH-1:0]    ch_en     = chan_q[CHAN_EN_LSB +: NCH];

  // Standby gates for diagnostics, general outputs and the switch
  sbk_gate_if #(.W(NERR)) diag_g ();
  sbk_gate_if #(.W(NGPO)) gpo_g ();
  sbk_gate_if #(.W(NCH))  sw_g ();
  assign diag_g.req     = err_en;
  assign diag_g.keep    = diag_keep;
  assign diag_g.standby = standby_i;
  assign gpo_g.req      = io_en;
  assign gpo_g.keep     = gpo_keep;
  assign gpo_g.standby  = standby_i;
  assign sw_g.req       = ch_sw & ch_en;
  assign sw_g.keep      = sw_keep;
  assign sw_g.standby   = standby_i;
  sbk_keep_gate #(.W(NERR)) u_diag_gate (.g(diag_g));
  sbk_keep_gate #(.W(NGPO)) u_gpo_gate  (.g(gpo_g));
  sbk_keep_gate #(.W(NCH))  u_sw_gate   (.g(sw_g));

  // Shared pin: indicator overrides the pin settings and the standby gate,
  // since it must stay low through standby to be of any use
  wire [NGPO-1:0] p2_mask = NGPO'(1) << PIN2_IDX;
  wire [NGPO-1:0] en_mux  = route ? (gpo_g.grant | p2_mask)
                                  : gpo_g.grant;
  wire [NGPO-1:0] lvl_ind = {NGPO{!standby_i}} & p2_mask;
  wire [NGPO-1:0] dat_mux = route ? ((io_dat & ~p2_mask) | lvl_ind)
                                  : io_dat;
  wire [NGPO-1:0] gpo_d   = en_mux & dat_mux;
  wire [NGPO-1:0] oe_n_d  = ~en_mux;

  // Oscillator needed only on the internal source: while converting, or in
  // standby only for kept over/undervoltage checks
  wire ovuv_on = |(err_q[7:0] & ERR_OVUV_MASK);
  wire clk_int = clk_sel == CLK_SEL_INT;
  wire osc_d   = clk_int && (!standby_i || (diag_keep && ovuv_on));
  wire sw_d    = |sw_g.grant;

  // Status word shows live standby state and the registered shared-pin level, switch and oscillator outputs
  wire [31:0] stat_w = {28'h000_0000, gpo_o[PIN2_IDX], lowside_sw_o,
                        osc_run_o, standby_i};
  wire [31:0] rd_mux = hit_misc ? misc_q :
                       hit_io   ? io_q   :
                       hit_err  ? err_q  :
                       hit_adc  ? adc_q  :
                       hit_chan ? chan_q :
                       hit_stat ? stat_w : 32'h0000_0000;

  // Register file
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      misc_q <= MISC_RST;
      io_q   <= IO_RST;
      err_q  <= ERR_RST;
      adc_q  <= ADC_RST;
      chan_q <= CHAN_RST;
    end else begin
      misc_q <= misc_d;
      io_q   <= io_d;
      err_q  <= err_d;
      adc_q  <= adc_d;
      chan_q <= chan_d;
    end
  end

  // Bus answer one cycle after the request; unmapped reads give zero
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q  <= 1'b0;
      rdat_q <= 32'h0000_0000;
    end else begin
      ack_q  <= req;
      rdat_q <= (req && !wb_we_i) ? rd_mux : 32'h0000_0000;
    end
  end
  assign wb_ack_o = ack_q;
  assign wb_dat_o = rdat_q;

  // Pin and keep-alive outputs, all registered
  logic [NGPO-1:0] gpo_q, oe_n_q;
  logic [NERR-1:0] diag_q;
  logic            osc_q, sw_q;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      gpo_q  <= '0;
      oe_n_q <= '1;
      diag_q <= '0;
      osc_q  <= 1'b0;
      sw_q   <= 1'b0;
    end else begin
      gpo_q  <= gpo_d;
      oe_n_q <= oe_n_d;
      diag_q <= diag_g.grant;
      osc_q  <= osc_d;
      sw_q   <= sw_d;
    end
  end
  assign gpo_o        = gpo_q;
  assign gpo_oe_n_o   = oe_n_q;
  assign diag_en_o    = diag_q;
  assign osc_run_o    = osc_q;
  assign lowside_sw_o = sw_q;

  // Checks on the registered outputs against their causes a cycle earlier
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  chk_route_standby_low: assert property (
    route && standby_i |=> !gpo_o[PIN2_IDX] && !gpo_oe_n_o[PIN2_IDX])
    else $error("indicator not low and driven in standby");

  chk_route_conv_high: assert property (
    route && !standby_i |=> gpo_o[PIN2_IDX] && !gpo_oe_n_o[PIN2_IDX])
    else $error("indicator not high while converting");

  chk_route_ignores_cfg: assert property (
    route && !io_en[PIN2_IDX] ##1 route && !io_en[PIN2_IDX]
      |-> $past(standby_i) != gpo_o[PIN2_IDX] && !gpo_oe_n_o[PIN2_IDX])
    else $error("pin settings leaked through while routed");

  chk_noroute_follow: assert property (
    !route && !standby_i |=> gpo_oe_n_o[PIN2_IDX] == !$past(io_en[PIN2_IDX])
      && gpo_o[PIN2_IDX] == ($past(io_en[PIN2_IDX]) && $past(io_dat[PIN2_IDX])))
    else $error("shared pin not following its settings");

  chk_noroute_no_ind: assert property (
    !route && !io_en[PIN2_IDX] |=> gpo_oe_n_o[PIN2_IDX] && !gpo_o[PIN2_IDX])
    else $error("indicator present while not routed");

  chk_diag_keep_on: assert property (
    standby_i && diag_keep |=> diag_en_o == $past(err_en))
    else $error("kept diagnostics dropped in standby");

  chk_diag_off: assert property (
    standby_i && !diag_keep |=> diag_en_o == '0)
    else $error("diagnostics alive in standby");

  chk_osc_kept: assert property (
    standby_i && diag_keep && ovuv_on && clk_int |=> osc_run_o)
    else $error("oscillator stopped though needed");

  chk_osc_stop: assert property (
    standby_i && !(diag_keep && ovuv_on) |=> !osc_run_o)
    else $error("oscillator left running in standby");

  chk_gpo_kept: assert property (
    standby_i && gpo_keep && !route |=> gpo_oe_n_o == ~$past(io_en))
    else $error("kept outputs dropped in standby");

  chk_gpo_off: assert property (
    standby_i && !gpo_keep && !route |=> &gpo_oe_n_o)
    else $error("outputs driving in standby");

  chk_sw_open: assert property (
    standby_i && !sw_keep |=> !lowside_sw_o)
    else $error("switch closed in standby");

  chk_sw_per_chan: assert property (
    standby_i && sw_keep |=> lowside_sw_o == |($past(ch_sw) & $past(ch_en)))
    else $error("switch ignores channel settings");

  chk_bus_ack_once: assert property (
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
    else $error("bus answer not a single cycle");

  // Read data: zero outside the answer cycle, the addressed word inside it
  chk_rdat_idle_zero: assert property (
    !wb_ack_o |-> wb_dat_o == 32'h0000_0000)
    else $error("read data not zero outside the answer");

  chk_rdat_write_zero: assert property (
    req && wb_we_i |=> wb_dat_o == 32'h0000_0000)
    else $error("read data shown on a write");

  chk_rd_misc_word: assert property (
    req && !wb_we_i && hit_misc |=> wb_dat_o == $past(misc_q))
    else $error("control word read back wrong");

  chk_rd_io_word: assert property (
    req && !wb_we_i && hit_io |=> wb_dat_o == $past(io_q))
    else $error("pin settings read back wrong");

  chk_rd_err_word: assert property (
    req && !wb_we_i && hit_err |=> wb_dat_o == $past(err_q))
    else $error("diagnostic mask read back wrong");

  chk_rd_adc_word: assert property (
    req && !wb_we_i && hit_adc |=> wb_dat_o == $past(adc_q))
    else $error("clock select read back wrong");

  chk_rd_chan_word: assert property (
    req && !wb_we_i && hit_chan |=> wb_dat_o == $past(chan_q))
    else $error("channel settings read back wrong");

  chk_rd_stat_word: assert property (
    req && !wb_we_i && hit_stat |=> wb_dat_o == $past(stat_w))
    else $error("status word read back wrong");

  chk_rd_unmapped: assert property (
    req && !wb_we_i && !(hit_misc || hit_io || hit_err || hit_adc || hit_chan || hit_stat)
      |=> wb_dat_o == 32'h0000_0000)
    else $error("unmapped read not zero");

  // Writes land in writable bits only; a write that leaves lane 1 unselected must not touch
  // the route bit, or a byte write to lane 0 could flip the shared pin by surprise
  chk_wr_misc_full: assert property (
    wr && hit_misc && wb_sel_i == 4'hF |=> misc_q == ($past(wb_dat_i) & MISC_WMASK))
    else $error("control write did not land");

  chk_wr_io_full: assert property (
    wr && hit_io && wb_sel_i == 4'hF |=> io_q == ($past(wb_dat_i) & IO_WMASK))
    else $error("pin settings write did not land");

  chk_wr_chan_full: assert property (
    wr && hit_chan && wb_sel_i == 4'hF |=> chan_q == ($past(wb_dat_i) & CHAN_WMASK))
    else $error("channel write did not land");

  chk_wr_lane_keep: assert property (
    wr && hit_misc && !wb_sel_i[1]
      |=> misc_q[MISC_ROUTE_BIT] == $past(misc_q[MISC_ROUTE_BIT]))
    else $error("unselected lane changed the route bit");

  chk_misc_hold: assert property (
    !(wr && hit_misc) |=> $stable(misc_q))
    else $error("control word changed without a write");

  chk_io_hold: assert property (
    !(wr && hit_io) |=> $stable(io_q))
    else $error("pin settings changed without a write");

  chk_misc_rsvd_zero: assert property (
    (misc_q & ~MISC_WMASK) == 32'h0000_0000)
    else $error("reserved control bits set");

  chk_err_rsvd_zero: assert property (
    (err_q & ~ERR_WMASK) == 32'h0000_0000)
    else $error("reserved mask bits set");

  // Outputs while converting, kept output levels in standby, and the pins that the indicator leaves alone
  chk_pin_idle_low: assert property (
    (gpo_o & gpo_oe_n_o) == {NGPO{1'b0}})
    else $error("released pin shows a high level");

  chk_route_others: assert property (
    route && !standby_i |=> ((gpo_oe_n_o ^ ~$past(io_en)) & ~p2_mask) == {NGPO{1'b0}})
    else $error("routing disturbed the other pins");

  chk_diag_conv: assert property (
    !standby_i |=> diag_en_o == $past(err_en))
    else $error("diagnostics not following the mask");

  chk_sw_conv: assert property (
    !standby_i |=> lowside_sw_o == |($past(ch_sw) & $past(ch_en)))
    else $error("switch not following channel settings");

  chk_osc_ext_off: assert property (
    !clk_int |=> !osc_run_o)
    else $error("oscillator on with an outside clock");

  chk_osc_conv_on: assert property (
    !standby_i && clk_int |=> osc_run_o)
    else $error("oscillator off while converting");

  chk_gpo_kept_lvl: assert property (
    standby_i && gpo_keep && !route |=> gpo_o == $past(io_en & io_dat))
    else $error("kept output levels lost in standby");

endmodule
`default_nettype wire

// >>> hdl/sbk_gate_if.sv
`default_nettype none
// Carries one group of enables through the standby keep gate
interface sbk_gate_if #(parameter int W = 8);
  logic [W-1:0] req;      // Enables as software set them
  logic         keep;     // Keep-alive bit for this group
  logic         standby;  // Converter is in standby
  logic [W-1:0] grant;    // Enables after standby gating
  modport src  (output req, output keep, output standby, input grant);
  modport gate (input req, input keep, input standby, output grant);
endinterface
`default_nettype wire

// >>> hdl/sbk_keep_gate.sv
`default_nettype none
// Passes a group of enables, cutting all of them in standby unless kept alive
module sbk_keep_gate #(
  parameter int W = 8
) (
  sbk_gate_if.gate g  // Enables in, gated enables out
);
  // Kept groups pass unchanged; others drop to zero while in standby
  assign g.grant = (g.standby && !g.keep) ? '0 : g.req;
endmodule
`default_nettype wire

// >>> hdl/sbk_pkg.sv
`default_nettype none
// Shared map and field layout of the standby keep-alive control block
package sbk_pkg;
  // Wishbone geometry
  localparam int WB_AW = 8;
  localparam int WB_DW = 32;
  // Register byte addresses
  localparam logic [7:0] ADR_MISC = 8'h00;
  localparam logic [7:0] ADR_IO   = 8'h04;
  localparam logic [7:0] ADR_ERR  = 8'h08;
  localparam logic [7:0] ADR_ADC  = 8'h0C;
  localparam logic [7:0] ADR_CHAN = 8'h10;
  localparam logic [7:0] ADR_STAT = 8'h14;
  // Standby control bits
  localparam int MISC_ROUTE_BIT = 8;
  localparam int MISC_DIAG_BIT  = 7;
  localparam int MISC_GPO_BIT   = 6;
  localparam int MISC_SW_BIT    = 5;
  // Pin settings: enables low byte, levels next byte
  localparam int IO_EN_LSB  = 0;
  localparam int IO_DAT_LSB = 8;
  // Diagnostics mask: low bits are over and undervoltage checks
  localparam logic [7:0] ERR_OVUV_MASK = 8'h03;
  // Clock source select field and the internal oscillator code
  localparam int         CLK_SEL_LSB = 0;
  localparam logic [1:0] CLK_SEL_INT = 2'h0;
  // Channel switch settings low byte, channel enables next byte
  localparam int CHAN_SW_LSB = 0;
  localparam int CHAN_EN_LSB = 8;
  // Status bit positions
  localparam int STAT_STANDBY = 0;
  localparam int STAT_OSC     = 1;
  localparam int STAT_SW      = 2;
  localparam int STAT_PIN2    = 3;
  // Index of the shared pin within the output group
  localparam int PIN2_IDX = 2;
  // Writable bits; everything else reads as zero
  localparam logic [31:0] MISC_WMASK = 32'h0000_01E0;
  localparam logic [31:0] IO_WMASK   = 32'h0000_FFFF;
  localparam logic [31:0] ERR_WMASK  = 32'h0000_00FF;
  localparam logic [31:0] ADC_WMASK  = 32'h0000_0003;
  localparam logic [31:0] CHAN_WMASK = 32'h0000_FFFF;
  // Reset values
  localparam logic [31:0] MISC_RST = 32'h0000_0000;
  localparam logic [31:0] IO_RST   = 32'h0000_0000;
  localparam logic [31:0] ERR_RST  = 32'h0000_0000;
  localparam logic [31:0] ADC_RST  = 32'h0000_0000;
  localparam logic [31:0] CHAN_RST = 32'h0000_0000;
endpackage
`default_nettype wire

// >>> sim/sbk_pin_watch.sv
`default_nettype none
// Outside circuit watching the shared pin, as it sees the wire
module sbk_pin_watch (
  input  wire logic clk_i,   // Bench clock
  input  wire logic lvl_i,   // Level driven by the block
  input  wire logic oe_n_i,  // Enable, low while driving
  output logic      pin_o    // Level seen on the wire
);
  timeunit 1ns;
  timeprecision 1ns;
  logic last_q;
  // Remember the last driven level
  always_ff @(posedge clk_i) begin
    if (!oe_n_i) last_q <= lvl_i;
  end
  // No pull on this pin: a released wire must not pass for the old level
  assign pin_o = oe_n_i ? ~last_q : lvl_i;
endmodule
`default_nettype wire

// >>> sim/tb_standby_keepalive_control.sv
`default_nettype none
module tb_standby_keepalive_control import sbk_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  logic             clk_i     = 1'b0;
  logic             rst_i     = 1'b1;
  logic             cyc       = 1'b0;
  logic             stb       = 1'b0;
  logic             we        = 1'b0;
  logic             standby   = 1'b0;
  logic [WB_AW-1:0] adr       = '0;
  logic [3:0]       sel       = 4'h0;
  logic [WB_DW-1:0] dat_w     = '0;
  logic [WB_DW-1:0] dat_r;
  logic [WB_DW-1:0] rd;
  logic [3:0]       general_purpose_output;
  logic [3:0]       oe_n;
  logic [7:0]       diag;
  logic             ack;
  logic             osc;
  logic             sw;
  logic             pin;
  int               err_total = 0;
  int               cmp_count = 0;
  int               cycles    = 0;

  sbk_ctrl uut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat_w), .wb_dat_o(dat_r), .wb_ack_o(ack),
    .standby_i(standby), .gpo_o(general_purpose_output), .gpo_oe_n_o(oe_n), .diag_en_o(diag),
    .osc_run_o(osc), .lowside_sw_o(sw));
  sbk_pin_watch watch (.clk_i(clk_i), .lvl_i(general_purpose_output[PIN2_IDX]), .oe_n_i(oe_n[PIN2_IDX]),
    .pin_o(pin));

  // Clock at 20 MHz
  initial begin
    forever #25 clk_i = ~clk_i;
  end

  // A hang is cut short well past the expected run length
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      err_total++;
      tally_and_finish();
    end
  end

  task automatic tally_and_finish();
    if (err_total == 0 && cmp_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_total++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // One classic bus cycle; ack is taken as sampled at the edge, read data with it
  task automatic wb_cycle(input logic w, input logic [7:0] a, input logic [31:0] d,
                          input logic [3:0] s);
    @(posedge clk_i);
    {cyc, stb, we, adr, dat_w, sel} <= {2'b11, w, a, d, s};
    do @(posedge clk_i); while (ack !== 1'b1);
    rd = dat_r;
    {cyc, stb, we} <= 3'b000;
  endtask

  // Program every register, set the core state, then compare all pin outputs
  task automatic scen(input logic [31:0] m, io, er, ck, ch, input logic sb,
                      input logic [3:0] e_gpo, e_oen, input logic [7:0] e_diag,
                      input logic e_osc, e_sw);
    wb_cycle(1'b1, ADR_MISC, m, 4'hF);
    wb_cycle(1'b1, ADR_IO, io, 4'hF);
    wb_cycle(1'b1, ADR_ERR, er, 4'hF);
    wb_cycle(1'b1, ADR_ADC, ck, 4'hF);
    wb_cycle(1'b1, ADR_CHAN, ch, 4'hF);
    standby <= sb;
    // Outputs lag one edge behind their cause
    repeat (2) @(posedge clk_i);
    check(32'(general_purpose_output), 32'(e_gpo));
    check(32'(oe_n), 32'(e_oen));
    check(32'(diag), 32'(e_diag));
    check(32'(osc), 32'(e_osc));
    check(32'(sw), 32'(e_sw));
    if (!e_oen[PIN2_IDX]) check(32'(pin), 32'(e_gpo[PIN2_IDX]));
  endtask

  initial begin
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    check(32'(oe_n), 32'hF);
    // Every mapped control register starts cleared
    for (int a = 0; a <= 16; a += 4) begin
      wb_cycle(1'b0, 8'(a), 32'h0, 4'hF);
      check(rd, 32'h0);
    end
    wb_cycle(1'b1, ADR_MISC, 32'hFFFF_FFFF, 4'h1);
    wb_cycle(1'b0, ADR_MISC, 32'h0, 4'hF);
    check(rd, 32'h0000_00E0);
    wb_cycle(1'b1, ADR_MISC, 32'hFFFF_FFFF, 4'hF);
    wb_cycle(1'b0, ADR_MISC, 32'h0, 4'hF);
    check(rd, MISC_WMASK);
    // Unmapped place: write dropped, read zero
    wb_cycle(1'b1, 8'h20, 32'hFFFF_FFFF, 4'hF);
    wb_cycle(1'b0, 8'h20, 32'h0, 4'hF);
    check(rd, 32'h0);
    scen(0, 32'h404, 0, 0, 0, '0, 4'h4, 4'hB, 8'h00, '1, '0);
    scen(0, 32'h004, 0, 0, 0, '0, 4'h0, 4'hB, 8'h00, '1, '0);
    scen(32'h100, 0, 0, 0, 0, '0, 4'h4, 4'hB, 8'h00, '1, '0);
    scen(32'h100, 0, 0, 0, 0, '1, 4'h0, 4'hB, 8'h00, '0, '0);
    scen(32'h100, 32'h404, 0, 0, 0, '1, 4'h0, 4'hB, 8'h00, '0, '0);
    scen(0, 32'hB0B, 0, 0, 0, '1, 4'h0, 4'hF, 8'h00, '0, '0);
    scen(32'h40, 32'hB0B, 0, 0, 0, '1, 4'hB, 4'h4, 8'h00, '0, '0);
    scen(0, 32'hB0B, 0, 0, 0, '0, 4'hB, 4'h4, 8'h00, '1, '0);
    scen(0, 0, 32'hFF, 0, 0, '1, 4'h0, 4'hF, 8'h00, '0, '0);
    scen(32'h80, 0, 32'hFF, 0, 0, '1, 4'h0, 4'hF, 8'hFF, '1, '0);
    scen(32'h80, 0, 32'hFF, 1, 0, '1, 4'h0, 4'hF, 8'hFF, '0, '0);
    scen(32'h80, 0, 32'hFC, 0, 0, '1, 4'h0, 4'hF, 8'hFC, '0, '0);
    scen(0, 0, 32'hFF, 0, 0, '0, 4'h0, 4'hF, 8'hFF, '1, '0);
    scen(0, 0, 0, 0, 32'h101, '1, 4'h0, 4'hF, 8'h00, '0, '0);
    scen(0, 0, 0, 0, 32'h101, '0, 4'h0, 4'hF, 8'h00, '1, '1);
    scen(32'h20, 0, 0, 0, 32'h101, '1, 4'h0, 4'hF, 8'h00, '0, '1);
    scen(32'h20, 0, 0, 0, 32'h001, '1, 4'h0, 4'hF, 8'h00, '0, '0);
    scen(32'h1E0, 32'hB0B, 3, 0, 32'h202, '1, 4'hB, 4'h0, 8'h03, '1, '1);
    wb_cycle(1'b0, ADR_STAT, 32'h0, 4'hF);
    check(rd, 32'h0000_0007);
    // Settings left by the last scenario read back as stored
    wb_cycle(1'b0, ADR_IO, 32'h0, 4'hF);
    check(rd, 32'h0000_0B0B);
    wb_cycle(1'b0, ADR_ERR, 32'h0, 4'hF);
    check(rd, 32'h0000_0003);
    wb_cycle(1'b0, ADR_CHAN, 32'h0, 4'hF);
    check(rd, 32'h0000_0202);
    // Reset in mid-run clears the control bits again
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    wb_cycle(1'b0, ADR_MISC, 32'h0, 4'hF);
    check(rd, 32'h0);
    tally_and_finish();
  end
endmodule
`default_nettype wire
